// ==== src/rtc_link_defines.svh ====
// constants shared by the rtc serial slave port and its bus master
`ifndef RTC_LINK_DEFINES_SVH
`define RTC_LINK_DEFINES_SVH
// ==========================================
// slave identifiers, upper seven bits of the slave byte
`define ID_CLOCK_REGS 7'h6F
`define ID_USER_MEM 7'h57
// ==========================================
// pointer limits and reset value
`define TOP_CLOCK_REGS 8'h2F
`define TOP_USER_MEM 8'h7F
`define PTR_RESET 8'h00
// ==========================================
// write fifo word: {space, address, data}
`define WF_DATA_LSB 0
`define WF_ADDR_LSB 8
`define WF_SPACE_BIT 16
`define WF_WIDTH 17
`define WF_DEPTH 4
// ==========================================
// timing: system clock and serial clock periods in ns
`define CLK_PERIOD_NS 40
`define SCL_PERIOD_NS 10000
// a quarter of the serial clock, rounded up to whole cycles
`define QTR_CYCLES ((`SCL_PERIOD_NS / 4 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== src/rtc_link_pkg.sv ====
// types of the rtc serial slave port and its bus master
`include "rtc_link_defines.svh"
package rtc_link_pkg;
	// ==========================================
	// slave end
	typedef enum logic [4:0] {
		D_IDLE = 5'h01, // standby, waits for a start
		D_RX = 5'h02, // shifting a byte in
		D_ACK = 5'h04, // holding the acknowledge low
		D_TX = 5'h08, // shifting a byte out
		D_MACK = 5'h10 // waiting for the master acknowledge
	} dev_fsm_t;
	typedef enum logic [1:0] {K_SLAVE = 2'h0, K_WORD = 2'h1, K_DATA = 2'h2} byte_kind_t;
	typedef struct packed {
		logic [2:0] scl_sync; // [0] first flop, [1] second, [2] delayed copy
		logic [2:0] sda_sync;
		dev_fsm_t fsm;
		byte_kind_t kind;
		logic [3:0] cnt; // bit counter within a byte
		logic [7:0] shift;
		logic rw; // direction bit of the slave byte
		logic space; // 1 selects user memory
		logic [7:0] ptr;
		logic sda_oe_n;
		logic acked;
		logic busy;
	} dev_state_t;
	// ==========================================
	// master end
	typedef enum logic [4:0] {
		M_IDLE = 5'h01,
		M_START = 5'h02,
		M_TX = 5'h04,
		M_RX = 5'h08,
		M_STOP = 5'h10
	} mst_fsm_t;
	typedef struct packed {
		logic [1:0] sda_sync;
		mst_fsm_t fsm;
		logic [2:0] stage; // 0 slave-w, 1 word, 2 data, 3 restart, 4 slave-r, 5 read
		logic [7:0] div;
		logic [1:0] q; // quarter of the current bit
		logic [3:0] bit_n;
		logic [7:0] shift;
		logic op_rd;
		logic no_addr;
		logic space;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] left;
		logic scl_oe_n;
		logic sda_oe_n;
		logic ready;
		logic rd_valid;
		logic [7:0] rd_data;
		logic done;
		logic nack;
	} mst_state_t;
endpackage

// ==== src/rtc_link_if.sv ====
// two-wire link between the bus master and the rtc slave port
`timescale 1ns/10ps
interface rtc_link_if;
	// ==========================================
	// open-drain drivers, enable low while pulling
	logic scl_o;
	logic scl_oe_n;
	logic msda_o;
	logic msda_oe_n;
	logic ssda_o;
	logic ssda_oe_n;
	// resolved wire levels with pull-ups
	logic scl;
	logic sda;
	assign scl = scl_oe_n ? 1'b1 : scl_o;
	assign sda = (msda_oe_n ? 1'b1 : msda_o) & (ssda_oe_n ? 1'b1 : ssda_o);
	modport master (output scl_o, output scl_oe_n, output msda_o, output msda_oe_n, input sda);
	modport slave (input scl, input sda, output ssda_o, output ssda_oe_n);
endinterface

// ==== src/rtc_i2c_slave_port.sv ====
// rtc serial slave port with its write fifo
//
// Behaviour
// - bytes shift most significant bit first
// - data changes only while clock low
// - data line released after reset
// - respond only after a start
// - ignore start during power-up
// - stop ends transfer, back to standby
// - transmitter releases after eight, receiver acknowledges
// - acknowledge slave, word and write bytes; a write byte gets no acknowledge while the fifo is full
// - keep sending only while master acknowledges
// - identifier selects registers or user memory
// - direction bit: one read, zero write
// - compare identifier after all eight bits
// - no word address means internal counter
// - counter cleared to first location
// - master repeats same identifier for reads
// - write is one byte then standby
// - master read sequence with repeated start
// - master stops after last byte
// - pointer loaded by word, increments per byte
// - register pointer wraps past top
// - silent while on battery
// - user memory spans 128 bytes
`timescale 1ns/10ps
`include "rtc_link_defines.svh"

// ==========================================
// slave port
module rtc_i2c_slave_port
	import rtc_link_pkg::*;
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// serial link
	rtc_link_if.slave LINK,
	// chip status, same clock
	input wire logic POWERUP_BUSY_IN,
	input wire logic ON_BATTERY_IN,
	// read side of the memories
	output logic RD_SPACE_OUT,
	output logic [7:0] RD_ADDR_OUT,
	input wire logic [7:0] RD_DATA_IN,
	// written bytes towards the memories
	output logic WR_VALID_OUT,
	input wire logic WR_READY_IN,
	output logic WR_SPACE_OUT,
	output logic [7:0] WR_ADDR_OUT,
	output logic [7:0] WR_DATA_OUT,
	// status
	output logic BUSY_OUT
);
	// syncs start at the idle-high wire level, so no false edge follows reset
	localparam dev_state_t DEV_RESET = '{fsm: D_IDLE, kind: K_SLAVE, sda_oe_n: 1'b1,
		scl_sync: 3'h7, sda_sync: 3'h7, ptr: `PTR_RESET, default: '0};
	dev_state_t cur_ff; // registered state
	dev_state_t nxt_state; // next state
	logic fifo_push; // one byte into the write fifo
	logic fifo_ready; // fifo has room
	logic [`WF_WIDTH-1:0] fifo_word; // registered fifo output

	// pointer step with wrap at the top of each space
	function automatic logic [7:0] step_ptr(input logic [7:0] p, input logic usr);
		logic [7:0] top;
		top = usr ? `TOP_USER_MEM : `TOP_CLOCK_REGS;
		step_ptr = (p == top) ? `PTR_RESET : p + 8'h01;
	endfunction

	// next state of the whole port
	always_comb begin
		logic scl_hi;
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda_now;
		logic [6:0] id;
		scl_hi = cur_ff.scl_sync[1] & cur_ff.scl_sync[2];
		start = scl_hi & cur_ff.sda_sync[2] & !cur_ff.sda_sync[1];
		stop = scl_hi & !cur_ff.sda_sync[2] & cur_ff.sda_sync[1];
		rise = cur_ff.scl_sync[1] & !cur_ff.scl_sync[2];
		fall = !cur_ff.scl_sync[1] & cur_ff.scl_sync[2];
		sda_now = cur_ff.sda_sync[1];
		id = cur_ff.shift[7:1];
		nxt_state = cur_ff;
		fifo_push = 1'b0;
		// pins pass two flops before anything looks at them
		nxt_state.scl_sync = {cur_ff.scl_sync[1:0], LINK.scl};
		nxt_state.sda_sync = {cur_ff.sda_sync[1:0], LINK.sda};
		if (ON_BATTERY_IN) begin
			// port dead on backup power, line left alone
			nxt_state.fsm = D_IDLE;
			nxt_state.sda_oe_n = 1'b1;
			nxt_state.busy = 1'b0;
		end else if (stop) begin
			// stop aborts whatever was going on
			nxt_state.fsm = D_IDLE;
			nxt_state.sda_oe_n = 1'b1;
			nxt_state.busy = 1'b0;
		end else if (start && !POWERUP_BUSY_IN) begin
			// start or repeated start, a slave byte follows
			nxt_state.fsm = D_RX;
			nxt_state.kind = K_SLAVE;
			nxt_state.cnt = 4'h0;
			nxt_state.sda_oe_n = 1'b1;
			nxt_state.busy = 1'b1;
		end else begin
			case (cur_ff.fsm)
				D_IDLE: begin
					// standby: only a start wakes the port
					nxt_state.busy = 1'b0;
				end
				D_RX: begin
					if (rise && cur_ff.cnt < 4'h8) begin
						// sample on the rising clock, msb arrives first
						nxt_state.shift = {cur_ff.shift[6:0], sda_now};
						nxt_state.cnt = cur_ff.cnt + 4'h1;
					end else if (fall && cur_ff.cnt == 4'h8) begin
						// whole byte in: decide on the acknowledge
						case (cur_ff.kind)
							K_SLAVE: begin
								// identifier checked only now
								if (id == `ID_CLOCK_REGS || id == `ID_USER_MEM) begin
									nxt_state.space = (id == `ID_USER_MEM);
									nxt_state.rw = cur_ff.shift[0];
									nxt_state.sda_oe_n = 1'b0;
									nxt_state.fsm = D_ACK;
								end else begin
									// not ours: stay off the bus
									nxt_state.fsm = D_IDLE;
								end
							end
							K_WORD: begin
								// word address loads the pointer
								nxt_state.ptr = cur_ff.space ? {1'b0, cur_ff.shift[6:0]} :
									cur_ff.shift;
								nxt_state.sda_oe_n = 1'b0;
								nxt_state.fsm = D_ACK;
							end
							default: begin
								// data byte: a full fifo refuses it with no acknowledge
								if (fifo_ready) begin
									fifo_push = 1'b1;
									nxt_state.ptr = step_ptr(cur_ff.ptr, cur_ff.space);
									nxt_state.sda_oe_n = 1'b0;
									nxt_state.fsm = D_ACK;
								end else begin
									nxt_state.fsm = D_IDLE;
								end
							end
						endcase
					end
				end
				D_ACK: begin
					if (fall) begin
						// ninth clock over: release, then the next phase
						nxt_state.sda_oe_n = 1'b1;
						nxt_state.cnt = 4'h0;
						case (cur_ff.kind)
							K_SLAVE: begin
								if (cur_ff.rw) begin
									// read with no word address uses the counter
									nxt_state.shift = RD_DATA_IN;
									nxt_state.sda_oe_n = RD_DATA_IN[7];
									nxt_state.fsm = D_TX;
								end else begin
									nxt_state.kind = K_WORD;
									nxt_state.fsm = D_RX;
								end
							end
							K_WORD: begin
								nxt_state.kind = K_DATA;
								nxt_state.fsm = D_RX;
							end
							default: begin
								// single byte write done, standby
								nxt_state.fsm = D_IDLE;
								nxt_state.busy = 1'b0;
							end
						endcase
					end
				end
				D_TX: begin
					if (rise) begin
						nxt_state.cnt = cur_ff.cnt + 4'h1;
					end else if (fall) begin
						if (cur_ff.cnt == 4'h8) begin
							// eight bits out: let go and advance the pointer
							nxt_state.sda_oe_n = 1'b1;
							nxt_state.ptr = step_ptr(cur_ff.ptr, cur_ff.space);
							nxt_state.fsm = D_MACK;
						end else begin
							// next bit only while the clock is low
							nxt_state.sda_oe_n = cur_ff.shift[3'(4'h7 - cur_ff.cnt)];
						end
					end
				end
				D_MACK: begin
					if (rise) begin
						nxt_state.acked = !sda_now;
					end else if (fall) begin
						if (cur_ff.acked) begin
							// acknowledged: send the next byte
							nxt_state.shift = RD_DATA_IN;
							nxt_state.sda_oe_n = RD_DATA_IN[7];
							nxt_state.cnt = 4'h0;
							nxt_state.fsm = D_TX;
						end else begin
							// no acknowledge: wait for the stop
							nxt_state.fsm = D_IDLE;
						end
					end
				end
				default: begin
					nxt_state.fsm = D_IDLE;
				end
			endcase
		end
	end

	// state register, line released from reset
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			cur_ff <= DEV_RESET;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	// write path buffer; a stalled drain makes the port refuse data
	rtc_word_fifo #(
		.WIDTH(`WF_WIDTH),
		.DEPTH(`WF_DEPTH)
	) u_fifo (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.s_valid_in(fifo_push),
		.s_ready_out(fifo_ready),
		.s_data_in({cur_ff.space, cur_ff.ptr, cur_ff.shift}),
		.m_valid_out(WR_VALID_OUT),
		.m_ready_in(WR_READY_IN),
		.m_data_out(fifo_word)
	);

	assign WR_SPACE_OUT = fifo_word[`WF_SPACE_BIT];
	assign WR_ADDR_OUT = fifo_word[`WF_ADDR_LSB +: 8];
	assign WR_DATA_OUT = fifo_word[`WF_DATA_LSB +: 8];
	assign RD_SPACE_OUT = cur_ff.space;
	assign RD_ADDR_OUT = cur_ff.ptr;
	assign BUSY_OUT = cur_ff.busy;
	assign LINK.ssda_o = 1'b0; // open drain: only ever pulls low
	assign LINK.ssda_oe_n = cur_ff.sda_oe_n;
endmodule // rtc_i2c_slave_port

// ==== src/rtc_link_master.sv ====
// two-wire bus master for the rtc slave port, and the word fifo of its write path
`timescale 1ns/10ps
`include "rtc_link_defines.svh"
module rtc_link_master
	import rtc_link_pkg::*;
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// serial link
	rtc_link_if.master LINK,
	// command
	input wire logic CMD_VALID_IN,
	output logic CMD_READY_OUT,
	input wire logic CMD_READ_IN,
	input wire logic CMD_NO_ADDR_IN,
	input wire logic CMD_SPACE_IN,
	input wire logic [7:0] CMD_ADDR_IN,
	input wire logic [7:0] CMD_WDATA_IN,
	input wire logic [7:0] CMD_COUNT_IN,
	// results
	output logic RD_VALID_OUT,
	output logic [7:0] RD_DATA_OUT,
	output logic DONE_OUT,
	output logic NACK_OUT
);
	localparam mst_state_t MST_RESET = '{fsm: M_IDLE, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
		ready: 1'b1, default: '0};
	mst_state_t cur_ff; // registered state
	mst_state_t nxt_state; // next state

	// next state: every bit is four quarters of the serial clock
	always_comb begin
		logic tick;
		logic rd_phase;
		logic [6:0] id;
		tick = (cur_ff.div == 8'(`QTR_CYCLES - 1));
		rd_phase = (cur_ff.stage == 3'h3) || (cur_ff.op_rd && cur_ff.no_addr);
		// same identifier in both phases of a read
		id = cur_ff.space ? `ID_USER_MEM : `ID_CLOCK_REGS;
		nxt_state = cur_ff;
		nxt_state.rd_valid = 1'b0;
		nxt_state.done = 1'b0;
		nxt_state.sda_sync = {cur_ff.sda_sync[0], LINK.sda};
		nxt_state.div = (cur_ff.fsm == M_IDLE || tick) ? 8'h00 : cur_ff.div + 8'h01;
		if (cur_ff.fsm == M_IDLE) begin
			// take a command, start from quarter zero
			if (CMD_VALID_IN) begin
				nxt_state.ready = 1'b0;
				nxt_state.nack = 1'b0;
				nxt_state.op_rd = CMD_READ_IN;
				nxt_state.no_addr = CMD_NO_ADDR_IN & CMD_READ_IN;
				nxt_state.space = CMD_SPACE_IN;
				nxt_state.addr = CMD_ADDR_IN;
				nxt_state.wdata = CMD_WDATA_IN;
				nxt_state.left = (CMD_COUNT_IN == 8'h00) ? 8'h01 : CMD_COUNT_IN;
				nxt_state.stage = 3'h0;
				nxt_state.q = 2'h0;
				nxt_state.fsm = M_START;
			end
		end else if (tick) begin
			nxt_state.q = cur_ff.q + 2'h1;
			case (cur_ff.fsm)
				M_START: begin
					// data falls while the clock is high
					case (cur_ff.q)
						2'h0: nxt_state.sda_oe_n = 1'b1;
						2'h1: nxt_state.scl_oe_n = 1'b1;
						2'h2: nxt_state.sda_oe_n = 1'b0;
						default: begin
							// clock low, slave byte with direction bit
							nxt_state.scl_oe_n = 1'b0;
							nxt_state.shift = {id, rd_phase};
							nxt_state.stage = rd_phase ? 3'h4 : 3'h0;
							nxt_state.bit_n = 4'h0;
							nxt_state.fsm = M_TX;
						end
					endcase
				end
				M_TX: begin
					case (cur_ff.q)
						// msb first, released for the ninth clock
						2'h0: nxt_state.sda_oe_n = (cur_ff.bit_n == 4'h8) ? 1'b1 : cur_ff.shift[7];
						2'h1: nxt_state.scl_oe_n = 1'b1;
						2'h2: begin
							if (cur_ff.bit_n == 4'h8) begin
								nxt_state.nack = cur_ff.sda_sync[1];
							end
						end
						default: begin
							nxt_state.scl_oe_n = 1'b0;
							nxt_state.shift = {cur_ff.shift[6:0], 1'b0};
							nxt_state.bit_n = cur_ff.bit_n + 4'h1;
							if (cur_ff.bit_n == 4'h8) begin
								nxt_state.bit_n = 4'h0;
								if (cur_ff.nack) begin
									// refused byte: give up with a stop
									nxt_state.fsm = M_STOP;
								end else if (cur_ff.stage == 3'h0) begin
									nxt_state.shift = cur_ff.addr;
									nxt_state.stage = 3'h1;
								end else if (cur_ff.stage == 3'h1 && cur_ff.op_rd) begin
									// repeated start for the read phase
									nxt_state.stage = 3'h3;
									nxt_state.fsm = M_START;
								end else if (cur_ff.stage == 3'h1) begin
									nxt_state.shift = cur_ff.wdata;
									nxt_state.stage = 3'h2;
								end else if (cur_ff.stage == 3'h4) begin
									nxt_state.stage = 3'h5;
									nxt_state.fsm = M_RX;
								end else begin
									nxt_state.fsm = M_STOP;
								end
							end
						end
					endcase
				end
				M_RX: begin
					case (cur_ff.q)
						// acknowledge all but the last byte
						2'h0: nxt_state.sda_oe_n = (cur_ff.bit_n == 4'h8) ? (cur_ff.left == 8'h01) : 1'b1;
						2'h1: nxt_state.scl_oe_n = 1'b1;
						2'h2: begin
							if (cur_ff.bit_n != 4'h8) begin
								nxt_state.shift = {cur_ff.shift[6:0], cur_ff.sda_sync[1]};
							end
						end
						default: begin
							nxt_state.scl_oe_n = 1'b0;
							nxt_state.bit_n = cur_ff.bit_n + 4'h1;
							if (cur_ff.bit_n == 4'h7) begin
								nxt_state.rd_valid = 1'b1;
								nxt_state.rd_data = cur_ff.shift;
							end else if (cur_ff.bit_n == 4'h8) begin
								nxt_state.bit_n = 4'h0;
								nxt_state.left = cur_ff.left - 8'h01;
								if (cur_ff.left == 8'h01) begin
									nxt_state.fsm = M_STOP;
								end
							end
						end
					endcase
				end
				M_STOP: begin
					// data rises while the clock is high
					case (cur_ff.q)
						2'h0: nxt_state.sda_oe_n = 1'b0;
						2'h1: nxt_state.scl_oe_n = 1'b1;
						2'h2: nxt_state.sda_oe_n = 1'b1;
						default: begin
							nxt_state.fsm = M_IDLE;
							nxt_state.done = 1'b1;
							nxt_state.ready = 1'b1;
						end
					endcase
				end
				default: begin
					nxt_state.fsm = M_IDLE;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			cur_ff <= MST_RESET;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	assign CMD_READY_OUT = cur_ff.ready;
	assign RD_VALID_OUT = cur_ff.rd_valid;
	assign RD_DATA_OUT = cur_ff.rd_data;
	assign DONE_OUT = cur_ff.done;
	assign NACK_OUT = cur_ff.nack;
	assign LINK.scl_o = 1'b0; // open drain: only ever pulls low
	assign LINK.scl_oe_n = cur_ff.scl_oe_n;
	assign LINK.msda_o = 1'b0;
	assign LINK.msda_oe_n = cur_ff.sda_oe_n;
endmodule // rtc_link_master

// ==========================================
// fifo
module rtc_word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// filling side
	input wire logic s_valid_in,
	output logic s_ready_out,
	input wire logic [WIDTH-1:0] s_data_in,
	// draining side
	output logic m_valid_out,
	input wire logic m_ready_in,
	output logic [WIDTH-1:0] m_data_out
);
	localparam int AW = $clog2(DEPTH); // depth must be a power of two
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] count;
		logic valid; // registered so the flags come from flops
		logic full;
		logic [WIDTH-1:0] head; // head word kept in a flop, no read mux on the output
	} fifo_state_t;
	fifo_state_t cur_ff; // registered state
	fifo_state_t nxt_state; // next state

	// next state: push and pop may happen together
	always_comb begin
		logic do_push;
		logic do_pop;
		do_push = s_valid_in && !cur_ff.full;
		do_pop = m_ready_in && cur_ff.valid;
		nxt_state = cur_ff;
		if (do_push) begin
			nxt_state.mem[cur_ff.wr] = s_data_in;
			nxt_state.wr = cur_ff.wr + 1'b1;
		end
		if (do_pop) begin
			nxt_state.rd = cur_ff.rd + 1'b1;
		end
		nxt_state.count = cur_ff.count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
		nxt_state.valid = (nxt_state.count != '0);
		nxt_state.full = (nxt_state.count == (AW+1)'(DEPTH));
		nxt_state.head = nxt_state.mem[nxt_state.rd];
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	assign s_ready_out = !cur_ff.full;
	assign m_valid_out = cur_ff.valid;
	assign m_data_out = cur_ff.head;
endmodule // rtc_word_fifo

// ==== bench/rtc_link_sva.sv ====
// concurrent checks on the two-wire link between the master and the rtc slave port
`timescale 1ns/10ps
module rtc_link_checker (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// resolved wires and open-drain enables
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe_n,
	input wire logic msda_oe_n,
	input wire logic ssda_oe_n,
	// slave status
	input wire logic POWERUP_BUSY_IN,
	input wire logic ON_BATTERY_IN,
	input wire logic BUSY_OUT
);
	logic scl_ff; // wire levels one cycle back
	logic sda_ff;
	logic frame_ff; // high between start and stop
	logic start_w; // start seen on the wires
	logic stop_w; // stop seen on the wires
	// ====================
	// wire conditions, seen without the slave's sync delay
	assign start_w = scl & scl_ff & ~sda & sda_ff;
	assign stop_w = scl & scl_ff & sda & ~sda_ff;
	// frame tracker, cleared by reset like the ends themselves
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			scl_ff <= 1'h1;
			sda_ff <= 1'h1;
			frame_ff <= 1'h0;
		end else begin
			scl_ff <= scl;
			sda_ff <= sda;
			frame_ff <= start_w ? 1'h1 : (stop_w ? 1'h0 : frame_ff);
		end
	end
	// ====================
	// properties, one clock domain
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);
	property p_reset_release;
		disable iff (1'h0) RST_IN |=> ssda_oe_n && msda_oe_n && scl_oe_n;
	endproperty
	a_reset_release: assert property (p_reset_release)
		else $error("link still pulled after reset");
	property p_change_scl_low;
		$changed(ssda_oe_n) |-> !scl && !$past(scl) && !$past(scl, 2);
	endproperty
	a_change_scl_low: assert property (p_change_scl_low)
		else $error("slave data moved while clock high");
	property p_idle_quiet;
		!frame_ff |-> ssda_oe_n;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("slave pulls data outside a frame");
	property p_start_busy;
		start_w && !POWERUP_BUSY_IN && !ON_BATTERY_IN |-> ##[1:6] BUSY_OUT;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("start not taken by slave");
	property p_stop_idle;
		stop_w |-> ##[1:6] !BUSY_OUT;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("slave not in standby after stop");
	property p_battery_quiet;
		ON_BATTERY_IN |=> ssda_oe_n && !BUSY_OUT;
	endproperty
	a_battery_quiet: assert property (p_battery_quiet)
		else $error("slave active on battery");
	property p_powerup_ignore;
		POWERUP_BUSY_IN && !BUSY_OUT |=> !BUSY_OUT;
	endproperty
	a_powerup_ignore: assert property (p_powerup_ignore)
		else $error("start taken during power-up");
	property p_bit_hold;
		$fell(ssda_oe_n) |-> (!ssda_oe_n) [*8];
	endproperty
	a_bit_hold: assert property (p_bit_hold)
		else $error("slave low bit too short");
endmodule // rtc_link_checker

// ==== bench/rtc_i2c_slave_port_tb_top.sv ====
// self-checking bench: master and rtc slave port joined by the link
`timescale 1ns/10ps
module rtc_i2c_slave_port_tb_top;
	// ====================
	// signals
	logic clk, rst, powerup_busy, on_battery, rd_space, wr_valid, wr_ready, wr_space, busy;
	logic [7:0] rd_addr, rd_data, wr_addr, wr_data, cmd_addr, cmd_wdata, cmd_count, rd_byte;
	logic cmd_valid, cmd_ready, cmd_read, cmd_no_addr, cmd_space, rd_valid, done, nack;
	logic [7:0] mem [0:511]; // memories behind the slave, index {space, address}
	logic [7:0] rq[$]; // expected read bytes
	logic [16:0] wq[$]; // expected fifo words {space, address, data}
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	// ====================
	// clock and design
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	rtc_link_if u_rtc_link_if ();
	rtc_i2c_slave_port u_rtc_i2c_slave_port (.CLK_IN(clk), .RST_IN(rst), .LINK(u_rtc_link_if),
		.POWERUP_BUSY_IN(powerup_busy), .ON_BATTERY_IN(on_battery), .RD_SPACE_OUT(rd_space),
		.RD_ADDR_OUT(rd_addr), .RD_DATA_IN(rd_data), .WR_VALID_OUT(wr_valid),
		.WR_READY_IN(wr_ready), .WR_SPACE_OUT(wr_space), .WR_ADDR_OUT(wr_addr),
		.WR_DATA_OUT(wr_data), .BUSY_OUT(busy));
	rtc_link_master u_rtc_link_master (.CLK_IN(clk), .RST_IN(rst), .LINK(u_rtc_link_if),
		.CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready), .CMD_READ_IN(cmd_read),
		.CMD_NO_ADDR_IN(cmd_no_addr), .CMD_SPACE_IN(cmd_space), .CMD_ADDR_IN(cmd_addr),
		.CMD_WDATA_IN(cmd_wdata), .CMD_COUNT_IN(cmd_count), .RD_VALID_OUT(rd_valid),
		.RD_DATA_OUT(rd_byte), .DONE_OUT(done), .NACK_OUT(nack));
	rtc_link_checker u_rtc_link_checker (.CLK_IN(clk), .RST_IN(rst),
		.scl(u_rtc_link_if.scl), .sda(u_rtc_link_if.sda), .scl_oe_n(u_rtc_link_if.scl_oe_n),
		.msda_oe_n(u_rtc_link_if.msda_oe_n), .ssda_oe_n(u_rtc_link_if.ssda_oe_n),
		.POWERUP_BUSY_IN(powerup_busy), .ON_BATTERY_IN(on_battery), .BUSY_OUT(busy));
	// read data answers at once from the model memory
	assign rd_data = mem[{rd_space, rd_addr}];
	// ====================
	// compare, verdict
	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one master command; expectations noted before it starts
	task automatic run_cmd(input logic rd, na, sp, input logic [7:0] ad, wd, cnt,
		input logic ex_nack);
		logic [7:0] p;
		int n;
		p = sp ? (ad & 8'h7F) : ad; // user word address is only seven bits
		n = (cnt == 8'h00) ? 1 : cnt;
		if (!ex_nack && !rd)
			wq.push_back({sp, p, wd});
		for (int i = 0; i < n && !ex_nack && rd; i++) begin
			rq.push_back(mem[{sp, p}]);
			p = (p == (sp ? 8'h7F : 8'h2F)) ? 8'h00 : p + 8'h01; // top wraps to first
		end
		@(posedge clk);
		#1;
		{cmd_read, cmd_no_addr, cmd_space, cmd_addr, cmd_wdata, cmd_count} = {rd, na, sp, ad, wd, cnt};
		cmd_valid = 1'h1;
		do @(posedge clk); while (cmd_ready !== 1'h1);
		#1 cmd_valid = 1'h0;
		do @(posedge clk); while (done !== 1'h1);
		chk("nack", {16'h0, ex_nack}, {16'h0, nack});
	endtask
	// ====================
	// monitor: oldest note against each result, fifo pops update memory
	always @(posedge clk) begin
		if (!rst) begin
			if (rd_valid === 1'h1)
				chk("read byte", (rq.size() != 0) ? rq.pop_front() : 17'hX, {9'h0, rd_byte});
			if (wr_valid === 1'h1 && wr_ready === 1'h1) begin
				chk("write word", (wq.size() != 0) ? wq.pop_front() : 17'hX,
					{wr_space, wr_addr, wr_data});
				mem[{wr_space, wr_addr}] = wr_data;
			end
		end
	end
	// hang guard, well above the ~80000 cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			chk("timeout", 17'h0, 17'h1);
			stop_test();
		end
	end
	// ====================
	// main sequence
	initial begin
		{rst, powerup_busy, on_battery, wr_ready, cmd_valid} = 5'h12;
		{cmd_read, cmd_no_addr, cmd_space, cmd_addr, cmd_wdata, cmd_count} = 27'h0;
		for (int i = 0; i < 512; i++)
			mem[i] = 8'(i * 37);
		void'($urandom(84171));
		repeat (3) @(posedge clk);
		#1 rst = 1'h0;
		repeat (4) @(posedge clk);
		run_cmd(1'h1, 1'h1, 1'h0, 8'h00, 8'h00, 8'h02, 1'h0);
		// start while powering up, then while on battery: no answer
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			#1 {on_battery, powerup_busy} = k ? 2'h2 : 2'h1;
			run_cmd(1'h0, 1'h0, k[0], 8'h10, 8'h3C, 8'h00, 1'h1);
		end
		// fifo stalled: four writes fit, the fifth data byte is refused
		@(posedge clk);
		#1 {on_battery, powerup_busy, wr_ready} = 3'h0;
		for (int k = 0; k < 5; k++)
			run_cmd(1'h0, 1'h0, k[0], 8'($urandom), 8'($urandom), 8'h00, k == 4);
		repeat (30) begin
			@(posedge clk);
			#1 wr_ready = 1'($urandom);
		end
		@(posedge clk);
		#1 wr_ready = 1'h1;
		repeat (8) @(posedge clk);
		#1 chk("fifo empty", 17'h0, {16'h0, wr_valid});
		// reads across the top of the register space, and up to the top of user memory
		run_cmd(1'h1, 1'h0, 1'h0, 8'h2E, 8'h00, 8'h03, 1'h0);
		run_cmd(1'h1, 1'h0, 1'h1, 8'hFE, 8'h00, 8'h02, 1'h0);
		repeat (4) @(posedge clk);
		chk("pending", 17'h0, 17'(rq.size() + wq.size()));
		stop_test();
	end
endmodule // rtc_i2c_slave_port_tb_top
